// [verilog/host_port_pkg.sv]
// Constants, mode codes and state types for the display host port.
// Assumes a single 40 MHz clock domain; all pin timing is slower than it.
package host_port_pkg;
    localparam int          DATA_W       = 8;
    localparam int          TAG_W        = DATA_W + 1;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          PIN_W        = 15;
    localparam logic [1:0]  SEL_SERIAL   = 2'h0;
    localparam logic [1:0]  SEL_I2C      = 2'h1;
    localparam logic [1:0]  SEL_P80      = 2'h2;
    localparam logic [1:0]  SEL_P68      = 2'h3;
    localparam int          SER_CLK_BIT  = 0;
    localparam int          SER_DIN_BIT  = 1;
    localparam int          I2C_SCL_BIT  = 0;
    localparam int          I2C_SDI_BIT  = 1;
    localparam int          I2C_SDO_BIT  = 2;
    localparam int          CTRL_DC_BIT  = 6;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  BIT_FIRST    = 3'h0;
    localparam logic [7:0]  BUS_IDLE     = 8'h00;
    localparam logic [7:0]  OE_ALL       = 8'hff;
    localparam logic [7:0]  OE_SDA       = 8'h04;
    localparam logic [14:0] PIN_RST      = 15'h7800;

    typedef enum logic [3:0] {
        MODE_SERIAL = 4'b0001,
        MODE_I2C    = 4'b0010,
        MODE_P80    = 4'b0100,
        MODE_P68    = 4'b1000
    } if_mode_t;

    typedef enum logic [4:0] {
        I2C_IDLE = 5'b00001,
        I2C_RECV = 5'b00010,
        I2C_WACK = 5'b00100,
        I2C_ACK  = 5'b01000,
        I2C_SKIP = 5'b10000
    } i2c_st_t;

    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_CTRL = 3'b010,
        PH_DATA = 3'b100
    } i2c_ph_t;
endpackage

// [verilog/pin_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to mclk_i.
`timescale 1ns/100ps
module pin_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Per bit: take a change only once two late stages agree
            q_o  <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_o);
        end
    end
endmodule

// [verilog/byte_fifo.sv]
// Small synchronous FIFO for received bytes.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              flush_i,
    input  wire logic              in_valid_i,
    output logic                   in_ready_o,
    input  wire logic [WIDTH-1:0]  in_data_i,
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output logic      [WIDTH-1:0]  out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      rptr_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wptr_r ^ rptr_r) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wptr_r != rptr_r;
    assign out_data_o  = mem_r[rptr_r[AW-1:0]];
    assign push        = in_valid_i && in_ready_o && !flush_i;
    assign pop         = out_valid_o && out_ready_i && !flush_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else if (flush_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule

// [verilog/display_host_port.sv]
// Host-facing front end of a monochrome display controller: four bus styles.
// Assumes all host pins are asynchronous and slow next to the 40 MHz clock.
// What this block does
// - The two bus select inputs pick serial, I2C, 80XX or 68XX host interface style.
// - While the reset pin is low the block initialises itself and accepts nothing.
// - Host activity counts only while chip select is low; otherwise it is ignored.
// - A parallel byte is display data when data/command is high, a command when low.
// - A serial byte is display data when data/command is high, a command when low.
// - In I2C mode the data/command pin becomes the low bit of the slave address.
// - In 68XX mode a transfer starts when enable rises while chip select is low.
// - In 68XX mode read/write high means a read and low means a write.
// - In 80XX mode a read starts when the read strobe falls with chip select low.
// - In 80XX mode a write starts when the write strobe falls with chip select low.
// - In parallel modes the eight data lines are driven on reads and sampled on writes.
// - In serial mode data line one is serial data in and data line zero the clock.
// - In I2C mode line two is data out, line one data in, and line zero the clock.
`timescale 1ns/100ps
module display_host_port
    import host_port_pkg::*;
#(
    parameter logic [5:0] I2C_ADDR_HI = 6'h10
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         reset_n_i,
    input  wire logic         bus_select_lo_i,
    input  wire logic         bus_select_hi_i,
    input  wire logic         chip_sel_n_i,
    input  wire logic         data_cmd_sel_i,
    input  wire logic         enable_or_read_n_i,
    input  wire logic         rw_or_write_n_i,
    input  wire logic [7:0]   host_data_i,
    output logic      [7:0]   host_data_o,
    output logic      [7:0]   host_data_oe_o,
    output logic              rx_valid_o,
    input  wire logic         rx_ready_i,
    output logic      [7:0]   rx_byte_o,
    output logic              rx_is_data_o,
    input  wire logic [7:0]   rd_data_i,
    output logic              rd_req_o,
    output logic              rd_is_data_o,
    output logic              init_o,
    output logic              overrun_o,
    output logic      [3:0]   mode_o
);
    function automatic if_mode_t sel_to_mode(input logic [1:0] sel);
        case (sel)
            SEL_SERIAL: sel_to_mode = MODE_SERIAL;
            SEL_I2C:    sel_to_mode = MODE_I2C;
            SEL_P80:    sel_to_mode = MODE_P80;
            default:    sel_to_mode = MODE_P68;
        endcase
    endfunction

    logic [PIN_W-1:0] pins;
    logic             res_n_s;
    logic             cs_n_s;
    logic             dc_s;
    logic             e_s;
    logic             rw_s;
    logic [7:0]       d_s;
    logic [1:0]       bs_s;
    logic             init;
    logic             cs_low;
    logic             e_q_r;
    logic             rw_q_r;
    logic             sclk_q_r;
    logic             sda_q_r;
    logic             scl_q_r;

    pin_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    ({reset_n_i, chip_sel_n_i, enable_or_read_n_i, rw_or_write_n_i, data_cmd_sel_i,
                  host_data_i, bus_select_hi_i, bus_select_lo_i}),
        .q_o    (pins)
    );

    assign {res_n_s, cs_n_s, e_s, rw_s, dc_s, d_s, bs_s} = pins;
    assign init   = !res_n_s;
    assign cs_low = !cs_n_s && !init;
    assign init_o = init;

    // Mode capture: straps caught during pin reset or first cycle after rstn_i reset
    if_mode_t mode_r;
    logic     mode_ok_r;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r    <= MODE_P68;
            mode_ok_r <= 1'b0;
        end else if (init || !mode_ok_r) begin
            mode_r    <= sel_to_mode(bs_s);
            mode_ok_r <= 1'b1;
        end
    end

    assign mode_o = mode_r;

    logic m68;
    logic m80;
    logic mser;
    logic mi2c;

    assign m68  = mode_r == MODE_P68;
    assign m80  = mode_r == MODE_P80;
    assign mser = mode_r == MODE_SERIAL;
    assign mi2c = mode_r == MODE_I2C;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            e_q_r    <= 1'b1;
            rw_q_r   <= 1'b1;
            sclk_q_r <= 1'b0;
            sda_q_r  <= 1'b0;
            scl_q_r  <= 1'b0;
        end else begin
            e_q_r    <= e_s;
            rw_q_r   <= rw_s;
            sclk_q_r <= d_s[SER_CLK_BIT];
            sda_q_r  <= d_s[I2C_SDI_BIT];
            scl_q_r  <= d_s[I2C_SCL_BIT];
        end
    end

    // Parallel strobes; strobe pins are grounded in serial modes, so gate by mode
    logic e_rise;
    logic e_fall;
    logic rw_rise;
    logic rw_fall;
    logic rd_start;
    logic wr_start;
    logic rd_end;
    logic wr_end;
    logic wr_armed_r;
    logic rd_act_r;
    logic par_push;

    assign e_rise   = e_s && !e_q_r;
    assign e_fall   = !e_s && e_q_r;
    assign rw_rise  = rw_s && !rw_q_r;
    assign rw_fall  = !rw_s && rw_q_r;
    assign rd_start = cs_low && ((m68 && e_rise && rw_s) || (m80 && e_fall));
    assign wr_start = cs_low && ((m68 && e_rise && !rw_s) || (m80 && rw_fall));
    assign rd_end   = !cs_low || (m68 && e_fall) || (m80 && e_rise) || !(m68 || m80);
    assign wr_end   = (m68 && e_fall) || (m80 && rw_rise);
    assign par_push = cs_low && wr_armed_r && wr_end;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_armed_r <= 1'b0;
        end else if (!cs_low || wr_end) begin
            wr_armed_r <= 1'b0;
        end else if (wr_start) begin
            wr_armed_r <= 1'b1;
        end
    end

    // Read data is captured at strobe start and held on the bus until it ends
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_act_r     <= 1'b0;
            host_data_o  <= BUS_IDLE;
            rd_is_data_o <= 1'b0;
        end else if (rd_start) begin
            rd_act_r     <= 1'b1;
            host_data_o  <= rd_data_i;
            rd_is_data_o <= dc_s;
        end else if (rd_end) begin
            rd_act_r     <= 1'b0;
            host_data_o  <= BUS_IDLE;
        end
    end

    assign rd_req_o = rd_start;

    // Serial receiver
    logic [6:0] ser_sh_r;
    logic [2:0] ser_cnt_r;
    logic       sclk_rise;
    logic       ser_push;

    assign sclk_rise = mser && cs_low && d_s[SER_CLK_BIT] && !sclk_q_r;
    assign ser_push  = sclk_rise && (ser_cnt_r == BIT_LAST);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ser_sh_r  <= '0;
            ser_cnt_r <= BIT_FIRST;
        end else if (!cs_low || !mser) begin
            ser_cnt_r <= BIT_FIRST;
        end else if (sclk_rise) begin
            ser_sh_r  <= {ser_sh_r[5:0], d_s[SER_DIN_BIT]};
            ser_cnt_r <= ser_cnt_r + 1'b1;
        end
    end

    // I2C write-only slave; reads are answered with no acknowledge
    i2c_st_t    i2c_st_r;
    i2c_ph_t    i2c_ph_r;
    logic [7:0] i2c_sh_r;
    logic [2:0] i2c_cnt_r;
    logic       i2c_dc_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       i2c_start;
    logic       i2c_stop;
    logic       addr_hit;
    logic       i2c_push;
    logic       fifo_rdy;

    assign scl_rise  = mi2c && d_s[I2C_SCL_BIT] && !scl_q_r;
    assign scl_fall  = mi2c && !d_s[I2C_SCL_BIT] && scl_q_r;
    assign i2c_start = mi2c && cs_low && d_s[I2C_SCL_BIT] && scl_q_r && sda_q_r && !d_s[I2C_SDI_BIT];
    assign i2c_stop  = mi2c && d_s[I2C_SCL_BIT] && scl_q_r && !sda_q_r && d_s[I2C_SDI_BIT];
    assign addr_hit  = i2c_sh_r == {I2C_ADDR_HI, dc_s, 1'b0};
    // A full FIFO turns into a not-acknowledge, so the host can retry
    assign i2c_push  = scl_fall && (i2c_st_r == I2C_WACK) && (i2c_ph_r == PH_DATA) && fifo_rdy;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            i2c_st_r  <= I2C_IDLE;
            i2c_ph_r  <= PH_ADDR;
            i2c_sh_r  <= '0;
            i2c_cnt_r <= BIT_FIRST;
            i2c_dc_r  <= 1'b0;
        end else if (!cs_low || !mi2c || i2c_stop) begin
            i2c_st_r  <= I2C_IDLE;
        end else if (i2c_start) begin
            i2c_st_r  <= I2C_RECV;
            i2c_ph_r  <= PH_ADDR;
            i2c_cnt_r <= BIT_FIRST;
        end else begin
            case (i2c_st_r)
                I2C_RECV: begin
                    if (scl_rise) begin
                        i2c_sh_r  <= {i2c_sh_r[6:0], d_s[I2C_SDI_BIT]};
                        i2c_cnt_r <= i2c_cnt_r + 1'b1;
                        if (i2c_cnt_r == BIT_LAST) begin
                            i2c_st_r <= I2C_WACK;
                        end
                    end
                end
                I2C_WACK: begin
                    if (scl_fall) begin
                        i2c_st_r <= I2C_ACK;
                        case (i2c_ph_r)
                            PH_ADDR: begin
                                if (addr_hit) begin
                                    i2c_ph_r <= PH_CTRL;
                                end else begin
                                    i2c_st_r <= I2C_SKIP;
                                end
                            end
                            PH_CTRL: begin
                                i2c_dc_r <= i2c_sh_r[CTRL_DC_BIT];
                                i2c_ph_r <= PH_DATA;
                            end
                            default: begin
                                if (!fifo_rdy) begin
                                    i2c_st_r <= I2C_SKIP;
                                end
                            end
                        endcase
                    end
                end
                I2C_ACK: begin
                    if (scl_fall) begin
                        i2c_st_r <= I2C_RECV;
                    end
                end
                I2C_SKIP: begin
                    i2c_st_r <= I2C_SKIP;
                end
                default: begin
                    i2c_st_r <= I2C_IDLE;
                end
            endcase
        end
    end

    // Bus drive: full byte on parallel reads, SDA pull-down during acknowledge
    always_comb begin
        host_data_oe_o = BUS_IDLE;
        if (rd_act_r && (m68 || m80)) begin
            host_data_oe_o = OE_ALL;
        end else if (i2c_st_r == I2C_ACK) begin
            host_data_oe_o = OE_SDA;
        end
    end

    // Byte stream into the FIFO
    logic             push_valid;
    logic [TAG_W-1:0] push_data;
    logic             overrun_r;

    assign push_valid = !init && (par_push || ser_push || i2c_push);

    always_comb begin
        push_data = {dc_s, d_s};
        if (mser) begin
            push_data = {dc_s, ser_sh_r, d_s[SER_DIN_BIT]};
        end else if (mi2c) begin
            push_data = {i2c_dc_r, i2c_sh_r};
        end
    end

    byte_fifo #(
        .WIDTH (TAG_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .flush_i     (init),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (push_data),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  ({rx_is_data_o, rx_byte_o})
    );

    // Parallel and serial hosts cannot be stalled; lost bytes are flagged
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            overrun_r <= 1'b0;
        end else if (push_valid && !fifo_rdy) begin
            overrun_r <= 1'b1;
        end else if (init) begin
            overrun_r <= 1'b0;
        end
    end

    assign overrun_o = overrun_r;

    sequence e_up_s;
        !e_q_r && e_s;
    endsequence

    sequence read_asked_s;
        m68 && cs_low && rw_s ##0 e_up_s;
    endsequence

    sequence wr_phase_s;
        m80 && cs_low && rw_fall ##1 (cs_low && !rw_s)[*1];
    endsequence

    idle_cs_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !cs_low |=> !rd_act_r && !wr_armed_r && (host_data_oe_o != OE_ALL))
        else $error("bus active while chip select high");

    init_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        init |=> !rx_valid_o && !overrun_r)
        else $error("activity during init");

    mode_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mode_ok_r && !init |=> $stable(mode_r))
        else $error("mode changed after reset");

    m68_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        read_asked_s |=> host_data_oe_o == OE_ALL && host_data_o == $past(rd_data_i))
        else $error("68xx read not served");

    m68_dir_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        m68 && cs_low && e_rise && !rw_s |=> wr_armed_r && !rd_act_r)
        else $error("68xx write taken as read");

    m80_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        m80 && cs_low && e_fall |=> rd_act_r ##0 host_data_oe_o == OE_ALL)
        else $error("80xx read not served");

    m80_arm_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_phase_s |-> wr_armed_r)
        else $error("80xx write not armed");

    m80_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        m80 && cs_low && wr_armed_r && rw_rise && !init |-> push_valid && push_data == {dc_s, d_s})
        else $error("80xx write not pushed");

    ser_byte_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ser_push |-> ser_cnt_r == BIT_LAST && push_data[7:1] == ser_sh_r && push_data[8] == dc_s)
        else $error("serial byte framing wrong");

    ser_nodrive_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mser |-> host_data_oe_o == BUS_IDLE)
        else $error("bus driven in serial mode");

    i2c_ack_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mi2c && i2c_st_r == I2C_WACK && i2c_ph_r == PH_ADDR && scl_fall && cs_low && !i2c_stop && !addr_hit
        |=> i2c_st_r == I2C_SKIP && host_data_oe_o == BUS_IDLE)
        else $error("foreign address acknowledged");
endmodule

// [verif/host_model.sv]
// Host microcontroller model: parallel, serial and I2C writers, parallel readers.
// Assumes the port's 40 MHz clock; each pin phase is held 3 to 8 cycles.
`timescale 1ns/100ps
module host_model
    import host_port_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] host_data_o,
    input  wire logic [7:0] host_data_oe_o,
    output logic            chip_sel_n_o,
    output logic            data_cmd_sel_o,
    output logic            enable_or_read_n_o,
    output logic            rw_or_write_n_o,
    output logic [7:0]      host_data_i_o
);
    logic [7:0] drv;
    logic       i2c_on;
    logic       sda;

    // I2C: lines one and two form one open-drain wire; the port only pulls it low
    assign sda           = drv[I2C_SDI_BIT] & ~(host_data_oe_o[I2C_SDO_BIT] & ~host_data_o[I2C_SDO_BIT]);
    // Port wins where it drives; the released host shows the inverse of its last value
    assign host_data_i_o = i2c_on ? {5'h00, sda, sda, drv[I2C_SCL_BIT]}
                                  : (host_data_oe_o & host_data_o) | (~host_data_oe_o & drv);

    initial begin
        chip_sel_n_o       = 1'b1;
        data_cmd_sel_o     = 1'b0;
        enable_or_read_n_o = 1'b0;
        rw_or_write_n_o    = 1'b0;
        drv                = 8'h00;
        i2c_on             = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic idle(input logic [1:0] sel);
        enable_or_read_n_o = (sel == SEL_P80);
        rw_or_write_n_o    = (sel == SEL_P80);
        drv                = 8'h00;
        i2c_on             = (sel == SEL_I2C);
    endtask

    task automatic par_wr(input logic p68, input logic cs_on, input logic dc, input logic [7:0] b);
        wt(1);
        chip_sel_n_o   = ~cs_on;
        data_cmd_sel_o = dc;
        drv            = b;
        if (p68) begin
            rw_or_write_n_o = 1'b0;
        end
        wt(6);
        if (p68) begin
            enable_or_read_n_o = 1'b1;
        end else begin
            rw_or_write_n_o = 1'b0;
        end
        wt(6);
        if (p68) begin
            enable_or_read_n_o = 1'b0;
        end else begin
            rw_or_write_n_o = 1'b1;
        end
        wt(6);
        chip_sel_n_o = 1'b1;
        drv          = ~b;
    endtask

    task automatic par_rd(input logic p68, input logic dc, output logic [7:0] b);
        wt(1);
        chip_sel_n_o   = 1'b0;
        data_cmd_sel_o = dc;
        drv            = ~drv;
        if (p68) begin
            rw_or_write_n_o = 1'b1;
        end
        wt(6);
        enable_or_read_n_o = p68;
        wt(8);
        b                  = host_data_i_o;
        enable_or_read_n_o = ~p68;
        wt(6);
        chip_sel_n_o = 1'b1;
        if (p68) begin
            rw_or_write_n_o = 1'b0;
        end
    endtask

    // Serial clock stands still outside frames
    task automatic ser_wr(input logic dc, input logic [7:0] b);
        wt(1);
        chip_sel_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            drv[SER_DIN_BIT] = b[i];
            data_cmd_sel_o   = dc;
            wt(3);
            drv[SER_CLK_BIT] = 1'b1;
            wt(3);
            drv[SER_CLK_BIT] = 1'b0;
        end
        wt(3);
        chip_sel_n_o = 1'b1;
        drv          = 8'h00;
    endtask

    // Three-byte I2C write; SDA only moves while SCL is low, bar START and STOP
    task automatic i2c_wr(input logic sa0, input logic [23:0] f, output logic [2:0] ack);
        wt(1);
        chip_sel_n_o     = 1'b0;
        data_cmd_sel_o   = sa0;
        drv[I2C_SCL_BIT] = 1'b1;
        drv[I2C_SDI_BIT] = 1'b1;
        wt(8);
        drv[I2C_SDI_BIT] = 1'b0;
        wt(6);
        drv[I2C_SCL_BIT] = 1'b0;
        for (int k = 2; k >= 0; k--) begin
            for (int i = 8; i >= 0; i--) begin
                drv[I2C_SDI_BIT] = (i == 0) ? 1'b1 : f[8*k + i - 1];
                wt(8);
                drv[I2C_SCL_BIT] = 1'b1;
                wt(3);
                if (i == 0) begin
                    ack[k] = !host_data_i_o[I2C_SDI_BIT];
                end
                wt(3);
                drv[I2C_SCL_BIT] = 1'b0;
            end
        end
        drv[I2C_SDI_BIT] = 1'b0;
        wt(8);
        drv[I2C_SCL_BIT] = 1'b1;
        wt(6);
        drv[I2C_SDI_BIT] = 1'b1;
        wt(6);
        chip_sel_n_o = 1'b1;
        drv          = 8'h00;
    endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the display host port.
// Assumes host_model drives the pins; bench owns straps, resets and sink.
`timescale 1ns/100ps
module testbench;
    import host_port_pkg::*;
    logic       mclk_i;
    logic       rstn_i;
    logic       reset_n;
    logic [1:0] straps;
    logic       cs_n;
    logic       dc;
    logic       en;
    logic       rw;
    logic [7:0] din;
    logic [7:0] dout;
    logic [7:0] doe;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] rx_byte;
    logic       rx_is_data;
    logic [7:0] rd_data;
    logic       rd_is_data;
    logic       init;
    logic       overrun;
    logic [3:0] mode;
    logic [7:0] got;
    logic [2:0] acks;
    logic       rd_req;
    int         rd_reqs;
    int         mismatches;
    int         checks_done;
    int         cycles;

    display_host_port dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reset_n_i(reset_n),
        .bus_select_lo_i(straps[0]), .bus_select_hi_i(straps[1]), .chip_sel_n_i(cs_n),
        .data_cmd_sel_i(dc), .enable_or_read_n_i(en), .rw_or_write_n_i(rw), .host_data_i(din),
        .host_data_o(dout), .host_data_oe_o(doe), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
        .rx_byte_o(rx_byte), .rx_is_data_o(rx_is_data), .rd_data_i(rd_data), .rd_req_o(rd_req),
        .rd_is_data_o(rd_is_data), .init_o(init), .overrun_o(overrun), .mode_o(mode));

    host_model host (.mclk_i(mclk_i), .host_data_o(dout), .host_data_oe_o(doe), .chip_sel_n_o(cs_n),
        .data_cmd_sel_o(dc), .enable_or_read_n_o(en), .rw_or_write_n_o(rw), .host_data_i_o(din));

    initial mclk_i = 1'b0;
    always #12.5 mclk_i = ~mclk_i;

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A stuck pin handshake would otherwise hang the run
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            test_done;
        end
    end

    // Each parallel read must raise exactly one request pulse
    always @(posedge mclk_i) begin
        if (rd_req === 1'b1) begin
            rd_reqs <= rd_reqs + 1;
        end
    end

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic pop(input logic [8:0] e);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        chk({rx_valid, rx_is_data, rx_byte}, {1'b1, e});
        rx_ready = 1'b1;
        @(negedge mclk_i);
        rx_ready = 1'b0;
    endtask

    // Straps are taken only while init is active or in the first cycle after rstn_i, so each mode change passes a reset pulse
    task automatic set_mode(input logic [1:0] sel);
        @(negedge mclk_i);
        straps  = sel;
        reset_n = 1'b0;
        host.idle(sel);
        repeat (10) @(negedge mclk_i);
        chk({9'h0, init}, 10'h001);
        reset_n = 1'b1;
        repeat (10) @(negedge mclk_i);
        chk({6'h0, mode}, {6'h0, 4'h1 << sel});
        chk({8'h0, overrun, rx_valid}, 10'h000);
    endtask

    initial begin
        rstn_i      = 1'b0;
        reset_n     = 1'b1;
        straps      = SEL_P68;
        rx_ready    = 1'b0;
        rd_data     = 8'h00;
        mismatches  = 0;
        checks_done = 0;
        cycles      = 0;
        rd_reqs     = 0;
        repeat (3) @(negedge mclk_i);
        rstn_i = 1'b1;
        set_mode(SEL_I2C);
        host.i2c_wr(1'b1, 24'h42405e, acks);
        chk({7'h0, acks}, 10'h007);
        pop(9'h15e);
        host.i2c_wr(1'b1, 24'h40405e, acks);
        chk({6'h0, acks, rx_valid}, 10'h000);
        set_mode(SEL_P68);
        host.par_wr(1'b1, 1'b1, 1'b1, 8'ha5);
        host.par_wr(1'b1, 1'b1, 1'b0, 8'h3c);
        host.par_wr(1'b1, 1'b0, 1'b1, 8'hff);
        pop(9'h1a5);
        pop(9'h03c);
        chk({9'h0, rx_valid}, 10'h000);
        rd_data = 8'h5a;
        host.par_rd(1'b1, 1'b1, got);
        chk({1'b0, rd_is_data, got}, 10'h15a);
        chk(10'(rd_reqs), 10'h001);
        set_mode(SEL_P80);
        host.par_wr(1'b0, 1'b1, 1'b0, 8'h81);
        pop(9'h081);
        rd_data = 8'hc6;
        host.par_rd(1'b0, 1'b0, got);
        chk({1'b0, rd_is_data, got}, 10'h0c6);
        chk(10'(rd_reqs), 10'h002);
        set_mode(SEL_SERIAL);
        host.ser_wr(1'b0, 8'hc3);
        host.ser_wr(1'b1, 8'h96);
        pop(9'h0c3);
        pop(9'h196);
        chk({2'h0, doe}, 10'h000);
        set_mode(SEL_P68);
        for (int i = 0; i < 9; i++) begin
            host.par_wr(1'b1, 1'b1, 1'b1, 8'(8'h10 + i));
        end
        chk({9'h0, overrun}, 10'h001);
        for (int i = 0; i < 8; i++) begin
            pop({1'b1, 8'(8'h10 + i)});
        end
        chk({9'h0, rx_valid}, 10'h000);
        set_mode(SEL_P68);
        test_done;
    end
endmodule
